// >>> rtl/sqf_status.sv
// Notes on behaviour
// - Stored enabled channel result at or below lower bound sets the below-bound flag.
// - Below-bound and overrun flags hold until the FIFO becomes empty.
// - Watermark mode: conversion dropped while FIFO locked sets overrun.
// - Streaming mode: full FIFO with no pop drops oldest entry, admits new, sets overrun.
// - Watermark flag set while sample count is at or above watermark.
// - Watermark flag clears once count falls below watermark; no latching.
// - Each interrupt follows its flag exactly; no acknowledge.
// - Status bits 3, 2, 1 are below-bound, overrun, watermark; reset zero.
// - Stored enabled channel result at or above upper bound sets above-bound flag.
// - Lower bound in threshold bits 11:0, upper bound in bits 23:12.
`timescale 1ns/1ps
module sqf_status (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [sqf_pkg::ADDR_W-1:0]       paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             conv_valid,
   input  wire logic [sqf_pkg::CH_W-1:0]         conv_channel,
   input  wire logic [sqf_pkg::DATA_W-1:0]       conv_data,
   input  wire logic                             fifo_pop,
   output logic                                  drop_oldest,
   output logic                                  irq_below,
   output logic                                  irq_above,
   output logic                                  irq_overrun,
   output logic                                  irq_watermark
);

   // Fill level and admission state
   logic [sqf_pkg::CNT_W-1:0]  count;
   logic [sqf_pkg::CNT_W-1:0]  next_count;
   logic                       locked;
   logic                       next_locked;
   logic                       accept;
   logic                       drop_new;
   logic                       evict;
   logic                       pop_ok;
   logic                       flush;
   logic                       becomes_empty;

   // Programmed settings
   logic [sqf_pkg::CNT_W-1:0]  wm_level;
   sqf_pkg::sqf_mode_t         mode;
   logic [sqf_pkg::THR_W-1:0]  lower_bound_value;
   logic [sqf_pkg::THR_W-1:0]  upper_bound_value;
   logic [sqf_pkg::NCH-1:0]    per_channel_compare_enable;

   // Status flags
   logic                       below_bound_flag;
   logic                       above_bound_flag;
   logic                       overrun_flag;
   logic                       watermark_flag;
   logic                       compare_on;
   logic                       below_hit;
   logic                       above_hit;

   // Register port
   logic                       setup;
   logic                       wr_en;
   logic                       map_hit;
   logic [31:0]                read_word;

   function automatic logic hits(input logic [sqf_pkg::ADDR_W-1:0] a,
                                 input logic [sqf_pkg::ADDR_W-1:0] off);
      return a == off;
   endfunction : hits

   // Zero wait states: ready follows the setup cycle
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   assign flush = wr_en && hits(paddr, sqf_pkg::OFF_CTRL) && pwdata[sqf_pkg::CTRL_FLUSH_BIT];

   // Admission of a new conversion
   always_comb begin
      accept   = 1'b0;
      drop_new = 1'b0;
      evict    = 1'b0;
      pop_ok   = fifo_pop && (count != sqf_pkg::CNT_ZERO);
      if (conv_valid) begin
         if (mode == sqf_pkg::SQF_STREAM) begin
            accept = 1'b1;
            // A pop in the same cycle makes room, so nothing is lost
            evict  = (count == sqf_pkg::CNT_FULL) && !pop_ok;
         end else if (locked || (count == sqf_pkg::CNT_FULL)) begin
            drop_new = 1'b1;
         end else begin
            accept = 1'b1;
         end
      end
   end

   // Fill level; flush beats any push or pop
   always_comb begin
      next_count = count;
      if (flush) begin
         next_count = sqf_pkg::CNT_ZERO;
      end else if (accept && !evict && !pop_ok) begin
         next_count = count + sqf_pkg::CNT_ONE;
      end else if (pop_ok && !accept) begin
         next_count = count - sqf_pkg::CNT_ONE;
      end
   end

   assign becomes_empty = (next_count == sqf_pkg::CNT_ZERO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= sqf_pkg::CNT_ZERO;
      end else begin
         count <= next_count;
      end
   end

   // Watermark mode treats the FIFO as full until it is emptied
   always_comb begin
      next_locked = locked;
      if ((mode == sqf_pkg::SQF_STREAM) || becomes_empty) begin
         next_locked = 1'b0;
      end else if (accept && (next_count >= wm_level)) begin
         next_locked = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked <= 1'b0;
      end else begin
         locked <= next_locked;
      end
   end

   // Only stored results are compared
   assign compare_on = accept && per_channel_compare_enable[conv_channel];

   sqf_bound_cmp u_cmp (
      .sample            (conv_data),
      .lower_bound_value (lower_bound_value),
      .upper_bound_value (upper_bound_value),
      .compare_on        (compare_on),
      .below             (below_hit),
      .above             (above_hit)
   );

   // Set wins over the emptying clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         below_bound_flag <= 1'b0;
      end else if (below_hit) begin
         below_bound_flag <= 1'b1;
      end else if (becomes_empty) begin
         below_bound_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         above_bound_flag <= 1'b0;
      end else if (above_hit) begin
         above_bound_flag <= 1'b1;
      end else if (becomes_empty) begin
         above_bound_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag <= 1'b0;
      end else if (drop_new || evict) begin
         overrun_flag <= 1'b1;
      end else if (becomes_empty) begin
         overrun_flag <= 1'b0;
      end
   end

   // Tracks the level, never latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watermark_flag <= 1'b0;
      end else begin
         watermark_flag <= (next_count >= wm_level);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_oldest <= 1'b0;
      end else begin
         drop_oldest <= evict;
      end
   end

   // Interrupts are the flag flops themselves
   assign irq_below     = below_bound_flag;
   assign irq_above     = above_bound_flag;
   assign irq_overrun   = overrun_flag;
   assign irq_watermark = watermark_flag;

   // Settings; bounds are assumed static while samples flow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wm_level <= sqf_pkg::RST_WMARK;
         mode     <= sqf_pkg::SQF_WATERMARK;
      end else if (wr_en && hits(paddr, sqf_pkg::OFF_CTRL)) begin
         wm_level <= pwdata[sqf_pkg::CTRL_WM_LSB +: sqf_pkg::CNT_W];
         mode     <= sqf_pkg::sqf_mode_t'(pwdata[sqf_pkg::CTRL_MODE_BIT]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lower_bound_value <= sqf_pkg::RST_LOW;
         upper_bound_value <= sqf_pkg::RST_HIGH;
      end else if (wr_en && hits(paddr, sqf_pkg::OFF_THRESH)) begin
         lower_bound_value <= pwdata[sqf_pkg::THR_LOW_LSB +: sqf_pkg::THR_W];
         upper_bound_value <= pwdata[sqf_pkg::THR_HIGH_LSB +: sqf_pkg::THR_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_channel_compare_enable <= sqf_pkg::RST_CHEN;
      end else if (wr_en && hits(paddr, sqf_pkg::OFF_CHEN)) begin
         per_channel_compare_enable <= pwdata[sqf_pkg::NCH-1:0];
      end
   end

   // Read decode
   always_comb begin
      read_word = '0;
      map_hit   = 1'b1;
      if (hits(paddr, sqf_pkg::OFF_STATUS)) begin
         read_word[sqf_pkg::BIT_ABOVE] = above_bound_flag;
         read_word[sqf_pkg::BIT_BELOW] = below_bound_flag;
         read_word[sqf_pkg::BIT_OVR]   = overrun_flag;
         read_word[sqf_pkg::BIT_WMARK] = watermark_flag;
      end else if (hits(paddr, sqf_pkg::OFF_CTRL)) begin
         read_word[sqf_pkg::CTRL_WM_LSB +: sqf_pkg::CNT_W] = wm_level;
         read_word[sqf_pkg::CTRL_MODE_BIT] = (mode == sqf_pkg::SQF_STREAM);
      end else if (hits(paddr, sqf_pkg::OFF_THRESH)) begin
         read_word[sqf_pkg::THR_LOW_LSB +: sqf_pkg::THR_W]  = lower_bound_value;
         read_word[sqf_pkg::THR_HIGH_LSB +: sqf_pkg::THR_W] = upper_bound_value;
      end else if (hits(paddr, sqf_pkg::OFF_CHEN)) begin
         read_word[sqf_pkg::NCH-1:0] = per_channel_compare_enable;
      end else if (hits(paddr, sqf_pkg::OFF_LEVEL)) begin
         read_word[sqf_pkg::CNT_W-1:0] = count;
      end else begin
         map_hit = 1'b0;
      end
   end

   // Read data is captured in setup so it stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !map_hit;
         if (setup) begin
            prdata <= read_word;
         end
      end
   end

   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_BELOW_SET: assert property (below_hit |=> below_bound_flag)
      else $error("below-bound flag missed a low sample");
   AST_BELOW_HOLD: assert property (below_bound_flag && !becomes_empty |=> below_bound_flag)
      else $error("below-bound flag dropped while samples remain");
   AST_OVR_HOLD: assert property (overrun_flag && !becomes_empty |=> overrun_flag)
      else $error("overrun flag dropped while samples remain");
   AST_FLAG_CLEAR: assert property ($fell(below_bound_flag) || $fell(overrun_flag) |-> count == sqf_pkg::CNT_ZERO)
      else $error("flag cleared with samples still stored");
   AST_WM_DROP: assert property (conv_valid && locked && mode == sqf_pkg::SQF_WATERMARK |=> overrun_flag)
      else $error("dropped conversion did not raise overrun");
   AST_EVICT: assert property (conv_valid && mode == sqf_pkg::SQF_STREAM && count == sqf_pkg::CNT_FULL && !fifo_pop |=> drop_oldest && overrun_flag)
      else $error("full stream fifo did not evict and flag overrun");
   AST_COUNT_MAX: assert property (count <= sqf_pkg::CNT_FULL)
      else $error("fill level beyond depth");
   AST_WMARK: assert property (watermark_flag == $past(next_count >= wm_level))
      else $error("watermark flag does not track fill level");

   COV_BELOW: cover property (below_hit);
   COV_WM_DROP: cover property (drop_new);
   COV_EVICT: cover property (evict);
   COV_WMARK: cover property ($rose(watermark_flag));
endmodule : sqf_status

// >>> rtl/sqf_pkg.sv
package sqf_pkg;
   localparam int          DEPTH        = 256;
   localparam int          CNT_W        = 9;
   localparam int          CH_W         = 4;
   localparam int          NCH          = 16;
   localparam int          DATA_W       = 16;
   localparam int          THR_W        = 12;
   localparam int          THR_LSB      = 4;
   localparam int          ADDR_W       = 8;
   localparam logic [CNT_W-1:0] CNT_FULL = 9'h100;
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;

   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CHEN   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_LEVEL  = 8'h10;

   localparam int BIT_WMARK = 1;
   localparam int BIT_OVR   = 2;
   localparam int BIT_BELOW = 3;
   localparam int BIT_ABOVE = 4;

   localparam int CTRL_WM_LSB    = 0;
   localparam int CTRL_MODE_BIT  = 16;
   localparam int CTRL_FLUSH_BIT = 31;
   localparam int THR_LOW_LSB    = 0;
   localparam int THR_HIGH_LSB   = 12;

   localparam logic [CNT_W-1:0] RST_WMARK = 9'h100;
   localparam logic [THR_W-1:0] RST_LOW   = 12'h000;
   localparam logic [THR_W-1:0] RST_HIGH  = 12'hfff;
   localparam logic [NCH-1:0]   RST_CHEN  = 16'h0000;

   typedef enum logic {SQF_WATERMARK, SQF_STREAM} sqf_mode_t;
endpackage : sqf_pkg

// >>> rtl/sqf_bound_cmp.sv
`timescale 1ns/1ps
module sqf_bound_cmp (
   input  wire logic [sqf_pkg::DATA_W-1:0] sample,
   input  wire logic [sqf_pkg::THR_W-1:0]  lower_bound_value,
   input  wire logic [sqf_pkg::THR_W-1:0]  upper_bound_value,
   input  wire logic                       compare_on,
   output logic                            below,
   output logic                            above
);
   // Bounds are 12 bits, so only the top of the result is compared
   logic [sqf_pkg::THR_W-1:0] top;
   assign top   = sample[sqf_pkg::DATA_W-1:sqf_pkg::THR_LSB];
   assign below = compare_on && (top <= lower_bound_value);
   assign above = compare_on && (top >= upper_bound_value);
endmodule : sqf_bound_cmp

// >>> tb/sqf_conv_src.sv
`timescale 1ns/1ps
module sqf_conv_src (
   input  wire logic        pclk,
   output logic             conv_valid,
   output logic [3:0]       conv_channel,
   output logic [15:0]      conv_data
);
   initial {conv_valid, conv_channel, conv_data} = '0;
   task automatic push(input logic [3:0] c, input logic [15:0] d);
      @(posedge pclk);
      {conv_valid, conv_channel, conv_data} <= {1'b1, c, d};
      @(posedge pclk);
      conv_valid <= 1'b0;
   endtask : push
endmodule : sqf_conv_src

// >>> tb/sqf_status_tb.sv
`timescale 1ns/1ps
module sqf_status_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fifo_pop = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, conv_valid, irq_below, irq_above, irq_overrun, irq_watermark, drop_oldest;
   logic [3:0] conv_channel;
   logic [15:0] conv_data;
   int errors = 0, compares = 0, cyc = 0, drops = 0;
   logic err;
   always #2 pclk = ~pclk;
   sqf_conv_src src (.pclk, .conv_valid, .conv_channel, .conv_data);
   sqf_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .conv_valid, .conv_channel, .conv_data, .fifo_pop, .drop_oldest, .irq_below,
      .irq_above, .irq_overrun, .irq_watermark);
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   always @(posedge pclk) if (drop_oldest === 1'b1) drops++;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : apb
   task automatic complete_run;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   always @(posedge pclk) if (++cyc > 5000) begin errors++; complete_run(); end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h0);
      apb(1, sqf_pkg::OFF_CTRL, 32'h1);
      apb(1, sqf_pkg::OFF_CHEN, 32'h1);
      apb(1, sqf_pkg::OFF_THRESH, 32'hfff010);
      apb(0, sqf_pkg::OFF_THRESH, 0); check("thresh", rd, 32'hfff010);
      src.push(4'h0, 16'h0000);
      repeat (4) @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'ha);
      check("irq", {irq_below, irq_overrun, irq_watermark}, 32'h5);
      fifo_pop <= 1'b1;
      @(posedge pclk) fifo_pop <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h0);
      check("irq", {irq_below, irq_overrun, irq_watermark}, 32'h0);
      src.push(4'h0, 16'hfff0);
      src.push(4'h0, 16'h0800);
      repeat (4) @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h16);
      check("irq", {irq_above, irq_overrun}, 32'h3);
      apb(0, sqf_pkg::OFF_LEVEL, 0); check("level", rd, 32'h1);
      fifo_pop <= 1'b1;
      @(posedge pclk) fifo_pop <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h0);
      apb(1, sqf_pkg::OFF_CTRL, 32'h00010100);
      repeat (257) src.push(4'h1, 16'h0000);
      repeat (4) @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h6);
      apb(0, sqf_pkg::OFF_LEVEL, 0); check("level", rd, 32'h100);
      check("drops", drops, 32'h1);
      check("irq_watermark", irq_watermark, 32'h1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, sqf_pkg::OFF_STATUS, 0); check("status", rd, 32'h0);
      apb(0, sqf_pkg::OFF_CTRL, 0); check("ctrl", rd, 32'h100);
      src.push(4'h1, 16'h0000);
      repeat (2) @(posedge pclk);
      apb(1, sqf_pkg::OFF_CTRL, 32'h80000100);
      apb(0, sqf_pkg::OFF_LEVEL, 0); check("level", rd, 32'h0);
      apb(0, 8'h14, 0); check("pslverr", err, 32'h1);
      complete_run();
   end
endmodule : sqf_status_tb
